// [hdl/fsp_pkg.sv]
// Package: constants, opcodes and field carriers for the flash status/protect block
// What this block does
// - Read-status answers anytime, even while busy
// - Status repeats while chip select stays low
// - Bit 0 high during write/program/erase
// - Bit 1 is latch; clear rejects writes except volatile status-writes
// - Bits 5..2 block-protect, set by status-write
// - Block-protect changes refused under hardware protection
// - Chip erase only with protect/boot-lock clear
// - Boot lock locks selected sector or block
// - Lock bit plus low pin: hardware protection
// - Protect pin inert until disable bit cleared
// - OTP mode remaps the upper status bits
// - Top/bottom select: 0 top, 1 bottom
// - Region size: 1 sector, 0 block
// - Disable bit or quad mode mutes pins
// - Hold/reset select picks pin function
// - OTP lock blocks OTP program and erase
// - OTP lock settable only once
// - Returned busy equals second register busy
// - Read-status also works in quad mode
// - Write-enable sets latch; completion clears it
// - Write-disable clears latch, leaves OTP mode
// - Volatile enable: next status-write volatile only
package fsp_pkg;
    // Opcodes
    localparam logic [7:0] FSP_OP_READ_STATUS_CMD = 8'h05;
    localparam logic [7:0] FSP_OP_WRITE_STATUS_CMD = 8'h01;
    localparam logic [7:0] FSP_OP_WRITE_ENABLE_CMD = 8'h06;
    localparam logic [7:0] FSP_OP_WRITE_DISABLE_CMD = 8'h04;
    localparam logic [7:0] FSP_OP_VWREN = 8'h50;
    localparam logic [7:0] FSP_OP_QUAD_ON = 8'h38;
    localparam logic [7:0] FSP_OP_QUAD_OFF = 8'hFF;
    localparam logic [7:0] FSP_OP_OTP_ENTER = 8'h3A;
    localparam logic [7:0] FSP_OP_PP = 8'h02;
    localparam logic [7:0] FSP_OP_QPP = 8'h32;
    localparam logic [7:0] FSP_OP_SE = 8'h20;
    localparam logic [7:0] FSP_OP_HBE = 8'h52;
    localparam logic [7:0] FSP_OP_BE = 8'hD8;
    localparam logic [7:0] FSP_OP_CE_A = 8'hC7;
    localparam logic [7:0] FSP_OP_CE_B = 8'h60;
    // Link bit counts
    localparam logic [5:0] FSP_CNT_OP = 6'h08;
    localparam logic [5:0] FSP_CNT_OPDAT = 6'h10;
    localparam logic [5:0] FSP_CNT_SAT = 6'h20;
    localparam logic [5:0] FSP_STEP_1 = 6'h01;
    localparam logic [5:0] FSP_STEP_4 = 6'h04;
    localparam logic [2:0] FSP_OUT_WRAP_1 = 3'h7;
    localparam logic [2:0] FSP_OUT_WRAP_4 = 3'h1;
    // Busy counter
    localparam int FSP_BUSY_W = 16;
    // Normal-mode upper fields (bits 7..2)
    typedef struct packed {
        logic status_lock_bit;
        logic boot_lock_enable;
        logic [3:0] block_protect;
    } fsp_norm_t;
    // OTP-mode upper fields (bits 7..3)
    typedef struct packed {
        logic otp_lock;
        logic pin_function_disable;
        logic hold_reset_select;
        logic region_size_select;
        logic top_bottom_select;
    } fsp_otp_t;
    // Protection view handed to the array engine
    typedef struct packed {
        logic [3:0] block_protect;
        logic boot_lock_enable;
        logic top_bottom_select;
        logic region_size_select;
        logic otp_locked;
    } fsp_prot_t;
    localparam fsp_norm_t FSP_NORM_RST = '{1'b0, 1'b0, 4'h0};
    localparam fsp_otp_t FSP_OTP_RST = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b0};
    typedef enum logic [1:0] {FSP_IDLE, FSP_BUSY_SR, FSP_BUSY_ARR} fsp_state_t;
endpackage

// [hdl/fsp_status_protect.sv]
// Flash status/protect register with read-status serial engine
module fsp_status_protect
    import fsp_pkg::*;
#(
    parameter logic [FSP_BUSY_W-1:0] SR_WRITE_CYCLES = 16'h0010,
    parameter logic [FSP_BUSY_W-1:0] ARRAY_OP_CYCLES = 16'h0040
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic [3:0] dq_i,
    output logic [3:0] dq_o,
    output logic [3:0] dq_oe,
    output logic busy_flag,
    output logic [7:0] status_protect_byte,
    output logic arr_start,
    output logic [7:0] arr_op,
    output fsp_prot_t arr_prot,
    output logic hold_active,
    output logic hw_reset_req,
    output logic hardware_protected_mode,
    output logic quad_command_mode,
    output logic otp_mode
);
    // ---------------- Link domain: rising edge input shifter ----------------
    logic [15:0] lk_sh_q;
    logic [5:0] lk_cnt_q;
    logic [7:0] lk_op_q;
    logic [15:0] lk_sh_d;
    logic [5:0] lk_cnt_d;
    logic [5:0] lk_step;
    logic [5:0] lk_base;
    logic lk_fresh_q;
    logic quad_q;

    // Quad mode only changes between frames, so it is static while sclk runs
    always_comb begin
        lk_step = quad_q ? FSP_STEP_4 : FSP_STEP_1;
        lk_base = lk_fresh_q ? 6'h00 : lk_cnt_q;
        lk_sh_d = quad_q ? {lk_sh_q[11:0], dq_i} : {lk_sh_q[14:0], dq_i[0]};
        lk_cnt_d = (lk_base < FSP_CNT_SAT) ? lk_base + lk_step : lk_base;
    end

    // Frame start marker: cs_n high arms it, the first rising edge of a frame clears it
    always_ff @(posedge sclk or posedge cs_n) begin
        if (cs_n) begin
            lk_fresh_q <= 1'b1;
        end else begin
            lk_fresh_q <= 1'b0;
        end
    end

    // Opcode and data sampled on rising edges; the count restarts with each frame
    // Not cleared by cs_n, so the clk side can still decode the finished frame
    always_ff @(posedge sclk) begin
        lk_sh_q <= lk_sh_d;
        lk_cnt_q <= lk_cnt_d;
        if (lk_cnt_d == FSP_CNT_OP) begin
            lk_op_q <= lk_sh_d[7:0];
        end
    end

    // ---------------- Link domain: status snapshot handshake ----------------
    logic snap_req_q;
    logic [7:0] snap_q;
    logic lk_req_s1_q, lk_req_s2_q, lk_ack_q;
    logic [7:0] lk_stat_q;

    // Falling-edge side takes a fresh snapshot whenever the toggle moves
    always_ff @(negedge sclk or negedge rst_n) begin
        if (!rst_n) begin
            lk_req_s1_q <= 1'b0;
            lk_req_s2_q <= 1'b0;
            lk_ack_q <= 1'b0;
            lk_stat_q <= 8'h00;
        end else begin
            lk_req_s1_q <= snap_req_q;
            lk_req_s2_q <= lk_req_s1_q;
            if (lk_req_s2_q != lk_ack_q) begin
                lk_stat_q <= snap_q;
                lk_ack_q <= lk_req_s2_q;
            end
        end
    end

    // ---------------- Link domain: falling edge status shifter ----------------
    logic [7:0] out_sh_q;
    logic [2:0] out_cnt_q;
    logic out_en_q;
    logic rd_go;

    assign rd_go = (lk_cnt_q >= FSP_CNT_OP) && (lk_op_q == FSP_OP_READ_STATUS_CMD);

    // Byte reloads each wrap so a held frame keeps polling live status
    always_ff @(negedge sclk or posedge cs_n) begin
        if (cs_n) begin
            out_sh_q <= 8'h00;
            out_cnt_q <= 3'h0;
            out_en_q <= 1'b0;
        end else if (rd_go) begin
            out_en_q <= 1'b1;
            if (out_cnt_q == 3'h0) begin
                out_sh_q <= (lk_req_s2_q != lk_ack_q) ? snap_q : lk_stat_q;
            end else begin
                out_sh_q <= quad_q ? {out_sh_q[3:0], 4'h0} : {out_sh_q[6:0], 1'b0};
            end
            if (out_cnt_q == (quad_q ? FSP_OUT_WRAP_4 : FSP_OUT_WRAP_1)) begin
                out_cnt_q <= 3'h0;
            end else begin
                out_cnt_q <= out_cnt_q + 3'h1;
            end
        end
    end

    // MSB first on DO in single mode, high nibble first in quad
    always_comb begin
        dq_o = 4'h0;
        dq_oe = 4'h0;
        if (out_en_q && !cs_n) begin
            if (quad_q) begin
                dq_o = out_sh_q[7:4];
                dq_oe = 4'hF;
            end else begin
                dq_o = {2'b00, out_sh_q[7], 1'b0};
                dq_oe = 4'h2;
            end
        end
    end

    // ---------------- System domain: pin synchronisers ----------------
    logic cs_s1_q, cs_s2_q, cs_s3_q;
    logic wp_s1_q, wp_s2_q, hold_s1_q, hold_s2_q;
    logic ack_s1_q, ack_s2_q;

    // Two flops ahead of any logic; third flop only for the edge detect
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cs_s1_q <= 1'b1;
            cs_s2_q <= 1'b1;
            cs_s3_q <= 1'b1;
            wp_s1_q <= 1'b1;
            wp_s2_q <= 1'b1;
            hold_s1_q <= 1'b1;
            hold_s2_q <= 1'b1;
            ack_s1_q <= 1'b0;
            ack_s2_q <= 1'b0;
        end else begin
            cs_s1_q <= cs_n;
            cs_s2_q <= cs_s1_q;
            cs_s3_q <= cs_s2_q;
            wp_s1_q <= dq_i[2];
            wp_s2_q <= wp_s1_q;
            hold_s1_q <= dq_i[3];
            hold_s2_q <= hold_s1_q;
            ack_s1_q <= lk_ack_q;
            ack_s2_q <= ack_s1_q;
        end
    end

    // ---------------- System domain: command decode ----------------
    logic frame_end;
    logic cmd1, cmd_wr;
    logic [7:0] cmd_op, cmd_dat;
    fsp_state_t st_q;
    logic wel_q, vol_arm_q, otp_q;
    fsp_norm_t norm_q;
    fsp_otp_t otp_cfg_q;
    logic [FSP_BUSY_W-1:0] busy_cnt_q;
    logic idle;
    logic is_prog, is_ce, arr_ok, ex_write_status_cmd, ex_vwrsr, ex_arr;

    // Link registers are frozen once cs_n is high, so reading them late is safe
    assign frame_end = cs_s2_q && !cs_s3_q;
    assign cmd_op = lk_op_q;
    assign cmd_dat = lk_sh_q[7:0];
    assign cmd1 = frame_end && (lk_cnt_q == FSP_CNT_OP);
    assign cmd_wr = frame_end && (lk_cnt_q == FSP_CNT_OPDAT) && (lk_op_q == FSP_OP_WRITE_STATUS_CMD);
    assign idle = (st_q == FSP_IDLE);

    assign is_prog = (cmd_op == FSP_OP_PP) || (cmd_op == FSP_OP_QPP) || (cmd_op == FSP_OP_SE)
        || (cmd_op == FSP_OP_HBE) || (cmd_op == FSP_OP_BE);
    assign is_ce = (cmd_op == FSP_OP_CE_A) || (cmd_op == FSP_OP_CE_B);
    // Chip erase only on a fully unprotected, unlocked array
    assign arr_ok = is_prog
        || (is_ce && (norm_q.block_protect == 4'h0) && !norm_q.boot_lock_enable);
    // Array commands end after their address; any frame length past the opcode counts
    assign ex_arr = frame_end && (lk_cnt_q >= FSP_CNT_OP) && arr_ok && wel_q && idle;
    assign ex_write_status_cmd = cmd_wr && idle && !vol_arm_q && wel_q && !hardware_protected_mode;
    assign ex_vwrsr = cmd_wr && idle && vol_arm_q && !hardware_protected_mode;

    // Hardware protection needs the lock bit, a low pin and live pin functions
    assign hardware_protected_mode = norm_q.status_lock_bit && !wp_s2_q
        && !otp_cfg_q.pin_function_disable && !quad_q;

    // Busy sequencer: one timed cycle per accepted non-volatile status-write or array operation
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_q <= FSP_IDLE;
            busy_cnt_q <= '0;
        end else begin
            unique case (st_q)
                FSP_IDLE: begin
                    if (ex_write_status_cmd) begin
                        st_q <= FSP_BUSY_SR;
                        busy_cnt_q <= SR_WRITE_CYCLES;
                    end else if (ex_arr) begin
                        st_q <= FSP_BUSY_ARR;
                        busy_cnt_q <= ARRAY_OP_CYCLES;
                    end
                end
                FSP_BUSY_SR, FSP_BUSY_ARR: begin
                    if (busy_cnt_q <= 16'h0001) begin
                        st_q <= FSP_IDLE;
                        busy_cnt_q <= '0;
                    end else begin
                        busy_cnt_q <= busy_cnt_q - 16'h0001;
                    end
                end
            endcase
        end
    end

    assign busy_flag = !idle;

    // Write-enable latch; completion of a timed cycle clears it
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wel_q <= 1'b0;
        end else if (!idle && busy_cnt_q <= 16'h0001) begin
            wel_q <= 1'b0;
        end else if (cmd1 && cmd_op == FSP_OP_WRITE_DISABLE_CMD) begin
            wel_q <= 1'b0;
        end else if (cmd1 && cmd_op == FSP_OP_WRITE_ENABLE_CMD && idle) begin
            wel_q <= 1'b1;
        end
    end

    // Volatile arm is consumed by the next status-write, or any other command except read-status
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            vol_arm_q <= 1'b0;
        end else if (cmd1 && cmd_op == FSP_OP_VWREN) begin
            vol_arm_q <= 1'b1;
        end else if (frame_end && lk_op_q != FSP_OP_READ_STATUS_CMD && lk_cnt_q >= FSP_CNT_OP) begin
            vol_arm_q <= 1'b0;
        end
    end

    // Mode flags: OTP view and quad command mode
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            otp_q <= 1'b0;
            quad_q <= 1'b0;
        end else begin
            if (cmd1 && cmd_op == FSP_OP_WRITE_DISABLE_CMD) begin
                otp_q <= 1'b0;
            end else if (cmd1 && cmd_op == FSP_OP_OTP_ENTER && idle) begin
                otp_q <= 1'b1;
            end
            if (cmd1 && cmd_op == FSP_OP_QUAD_ON && !quad_q) begin
                quad_q <= 1'b1;
            end else if (cmd1 && cmd_op == FSP_OP_QUAD_OFF && quad_q) begin
                quad_q <= 1'b0;
            end
        end
    end

    // Normal-mode fields: only written outside OTP mode and outside protection
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            norm_q <= FSP_NORM_RST;
        end else if ((ex_write_status_cmd || ex_vwrsr) && !otp_q) begin
            norm_q <= cmd_dat[7:2];
        end
    end

    // OTP fields: programming only sets bits, volatile write may clear the rest
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            otp_cfg_q <= FSP_OTP_RST;
        end else if (ex_write_status_cmd && otp_q) begin
            otp_cfg_q <= otp_cfg_q | fsp_otp_t'(cmd_dat[7:3]);
        end else if (ex_vwrsr && otp_q) begin
            otp_cfg_q.pin_function_disable <= cmd_dat[6];
            otp_cfg_q.hold_reset_select <= cmd_dat[5];
            otp_cfg_q.region_size_select <= cmd_dat[4];
            otp_cfg_q.top_bottom_select <= cmd_dat[3];
        end
    end

    // Status view switches layout with the mode
    always_comb begin
        if (otp_q) begin
            status_protect_byte = {otp_cfg_q, 1'b0, wel_q, busy_flag};
        end else begin
            status_protect_byte = {norm_q, wel_q, busy_flag};
        end
    end

    // Snapshot to the link: reload only after the last one was acknowledged
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            snap_q <= 8'h00;
            snap_req_q <= 1'b0;
        end else if (snap_req_q == ack_s2_q && snap_q != status_protect_byte) begin
            snap_q <= status_protect_byte;
            snap_req_q <= !snap_req_q;
        end
    end

    // Array engine handoff: start pulse with opcode; OTP lock guards its sector
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            arr_start <= 1'b0;
            arr_op <= 8'h00;
            arr_prot <= '0;
        end else begin
            arr_start <= ex_arr;
            if (ex_arr) begin
                arr_op <= cmd_op;
            end
            arr_prot.block_protect <= norm_q.block_protect;
            arr_prot.boot_lock_enable <= norm_q.boot_lock_enable;
            arr_prot.top_bottom_select <= otp_cfg_q.top_bottom_select;
            arr_prot.region_size_select <= otp_cfg_q.region_size_select;
            arr_prot.otp_locked <= otp_cfg_q.otp_lock;
        end
    end

    // Shared pin: hold or reset, only when pin functions are live and not in quad
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            hold_active <= 1'b0;
            hw_reset_req <= 1'b0;
        end else begin
            hold_active <= !otp_cfg_q.pin_function_disable && !quad_q
                && !otp_cfg_q.hold_reset_select && !hold_s2_q;
            hw_reset_req <= !otp_cfg_q.pin_function_disable && !quad_q
                && otp_cfg_q.hold_reset_select && !hold_s2_q;
        end
    end

    assign quad_command_mode = quad_q;
    assign otp_mode = otp_q;

    // ---------------- Assertions ----------------
    a_wel_gates_ops: assert property (@(posedge clk) disable iff (!rst_n)
        (ex_arr || ex_write_status_cmd) |-> wel_q) else $error("write op without latch");
    a_busy_follows: assert property (@(posedge clk) disable iff (!rst_n)
        (ex_write_status_cmd || ex_arr) |=> busy_flag [*3]) else $error("busy not held");
    a_busy_bit: assert property (@(posedge clk) disable iff (!rst_n)
        status_protect_byte[0] == (busy_cnt_q != '0))
        else $error("bit 0 not busy");
    a_hpm_freeze: assert property (@(posedge clk) disable iff (!rst_n)
        (hardware_protected_mode && cmd_wr) |=> $stable(norm_q)) else $error("protect broke");
    a_ce_clean: assert property (@(posedge clk) disable iff (!rst_n)
        (ex_arr && is_ce) |-> (norm_q.block_protect == 4'h0 && !norm_q.boot_lock_enable))
        else $error("chip erase while protected");
    a_otp_lock_once: assert property (@(posedge clk) disable iff (!rst_n)
        $past(otp_cfg_q.otp_lock) |-> otp_cfg_q.otp_lock) else $error("otp lock cleared");
    a_pins_muted: assert property (@(posedge clk) disable iff (!rst_n)
        ($past(otp_cfg_q.pin_function_disable) || $past(quad_q)) |-> !(hold_active || hw_reset_req))
        else $error("pin active while disabled");
    a_write_disable_cmd_exit: assert property (@(posedge clk) disable iff (!rst_n)
        (cmd1 && cmd_op == FSP_OP_WRITE_DISABLE_CMD && idle) |=> (!otp_q && !wel_q))
        else $error("write-disable ignored");
    a_done_clears: assert property (@(posedge clk) disable iff (!rst_n)
        $fell(busy_flag) |-> !wel_q) else $error("latch survives cycle");
    a_hpm_pin: assert property (@(posedge clk) disable iff (!rst_n)
        otp_cfg_q.pin_function_disable |-> !hardware_protected_mode)
        else $error("protect pin live while disabled");

    c_poll_busy: cover property (@(posedge clk) disable iff (!rst_n)
        busy_flag && frame_end && lk_op_q == FSP_OP_READ_STATUS_CMD);
    c_write_status_cmd_done: cover property (@(posedge clk) disable iff (!rst_n) ex_write_status_cmd ##[1:40] !busy_flag);
    c_chip_erase: cover property (@(posedge clk) disable iff (!rst_n) ex_arr && is_ce);
    c_quad_read: cover property (@(posedge clk) disable iff (!rst_n)
        quad_q && frame_end && lk_op_q == FSP_OP_READ_STATUS_CMD);
endmodule

// [verif/flash_status_protect_register_tb.sv]
// Self-checking bench for the status/protect register over the serial link
module flash_status_protect_register_tb import fsp_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk;
    logic rst_n;
    logic sclk, cs_n, busy_flag, arr_start, hold_active, hw_reset_req;
    logic hardware_protected_mode, quad_command_mode, otp_mode;
    logic [3:0] dq_i, dq_o, dq_oe;
    logic [7:0] status_protect_byte, arr_op;
    fsp_prot_t arr_prot;
    int err_count = 0;
    int cmp_count = 0;
    int n_arr = 0;
    int n0;
    logic [7:0] ops[7] = '{FSP_OP_PP, FSP_OP_QPP, FSP_OP_SE, FSP_OP_HBE, FSP_OP_BE,
        FSP_OP_CE_A, FSP_OP_CE_B};
    fsp_status_protect #(.SR_WRITE_CYCLES(16'h0020), .ARRAY_OP_CYCLES(16'h0020)) dut (
        .clk(clk), .rst_n(rst_n), .sclk(sclk), .cs_n(cs_n), .dq_i(dq_i), .dq_o(dq_o),
        .dq_oe(dq_oe), .busy_flag(busy_flag), .status_protect_byte(status_protect_byte),
        .arr_start(arr_start), .arr_op(arr_op), .arr_prot(arr_prot),
        .hold_active(hold_active), .hw_reset_req(hw_reset_req),
        .hardware_protected_mode(hardware_protected_mode),
        .quad_command_mode(quad_command_mode), .otp_mode(otp_mode));
    fsp_host_model host (.sclk(sclk), .cs_n(cs_n), .dq_i(dq_i), .dq_o(dq_o),
        .dq_oe(dq_oe));
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // Accepted array operations, counted from the one-cycle start pulse
    always @(posedge clk) begin
        if (arr_start === 1'b1) n_arr <= n_arr + 1;
    end
    task automatic results();
        $display("Comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_count++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic cmd(input logic [7:0] op, input logic [7:0] d, input int nb);
        logic [7:0] rd;
        host.xfer(op, d, nb, rd);
    endtask
    // Holds the frame for two repeats and checks the second copy
    task automatic read_status_cmd(input logic [7:0] exp);
        logic [7:0] rd;
        host.xfer(FSP_OP_READ_STATUS_CMD, 8'h00, 24, rd);
        chk("status", rd, exp);
        chk("out enable", {4'h0, host.oe_last}, host.quad ? 8'h0F : 8'h02);
    endtask
    // Polls until the busy bit clears; a long wait ends the run
    task automatic poll_idle();
        logic [7:0] rd;
        for (int i = 0; i < 20; i++) begin
            host.xfer(FSP_OP_READ_STATUS_CMD, 8'h00, 16, rd);
            chk("busy mirror", {7'h0, busy_flag}, {7'h0, status_protect_byte[0]});
            if (rd[0] === 1'b0) return;
        end
        err_count++;
        results();
    endtask
    initial begin
        #1000000;
        err_count++;
        results();
    end
    initial begin
        #1 rst_n = 1'b0; // One step in, so the async handshake reset sees an edge
        repeat (2) @(negedge clk);
        rst_n = 1'b1;
        repeat (4) @(negedge clk);
        chk("reset view", status_protect_byte, 8'h00);
        chk("modes", {6'h0, quad_command_mode, otp_mode}, 8'h00);
        cmd(FSP_OP_WRITE_STATUS_CMD, 8'h3C, 16);
        read_status_cmd(8'h00);
        cmd(FSP_OP_WRITE_ENABLE_CMD, 8'h00, 8);
        read_status_cmd(8'h02);
        cmd(FSP_OP_WRITE_STATUS_CMD, 8'h3C, 16);
        read_status_cmd(8'h3F);
        poll_idle();
        read_status_cmd(8'h3C);
        n0 = n_arr;
        cmd(FSP_OP_WRITE_ENABLE_CMD, 8'h00, 8);
        cmd(FSP_OP_CE_A, 8'h00, 8);
        chk("erase refused", 8'(n_arr - n0), 8'h00);
        cmd(FSP_OP_WRITE_ENABLE_CMD, 8'h00, 8);
        cmd(FSP_OP_WRITE_STATUS_CMD, 8'h40, 16);
        poll_idle();
        chk("boot lock", {7'h0, arr_prot.boot_lock_enable}, 8'h01);
        cmd(FSP_OP_WRITE_ENABLE_CMD, 8'h00, 8);
        cmd(FSP_OP_CE_B, 8'h00, 8);
        chk("boot erase", 8'(n_arr - n0), 8'h00);
        cmd(FSP_OP_WRITE_ENABLE_CMD, 8'h00, 8);
        cmd(FSP_OP_WRITE_STATUS_CMD, 8'h00, 16);
        poll_idle();
        cmd(FSP_OP_PP, 8'h00, 32);
        chk("no latch", 8'(n_arr - n0), 8'h00);
        // Every array opcode with the latch set and nothing protected
        foreach (ops[k]) begin
            cmd(FSP_OP_WRITE_ENABLE_CMD, 8'h00, 8);
            cmd(ops[k], 8'h00, 32);
            chk("array op", arr_op, ops[k]);
            chk("array busy", {7'h0, busy_flag}, 8'h01);
            poll_idle();
        end
        chk("array count", 8'(n_arr - n0), 8'h07);
        read_status_cmd(8'h00);
        cmd(FSP_OP_WRITE_ENABLE_CMD, 8'h00, 8);
        cmd(FSP_OP_WRITE_DISABLE_CMD, 8'h00, 8);
        read_status_cmd(8'h00);
        cmd(FSP_OP_WRITE_ENABLE_CMD, 8'h00, 8);
        cmd(FSP_OP_WRITE_STATUS_CMD, 8'h3C, 17);
        read_status_cmd(8'h02);
        cmd(FSP_OP_WRITE_DISABLE_CMD, 8'h00, 8);
        cmd(FSP_OP_VWREN, 8'h00, 8);
        cmd(FSP_OP_WRITE_STATUS_CMD, 8'h8C, 16);
        read_status_cmd(8'h8C);
        @(negedge clk);
        host.wp_n = 1'b0;
        repeat (4) @(negedge clk);
        chk("pin inert", {7'h0, hardware_protected_mode}, 8'h00);
        cmd(FSP_OP_OTP_ENTER, 8'h00, 8);
        chk("otp mode", {7'h0, otp_mode}, 8'h01);
        read_status_cmd(8'h40);
        cmd(FSP_OP_VWREN, 8'h00, 8);
        cmd(FSP_OP_WRITE_STATUS_CMD, 8'h18, 16);
        read_status_cmd(8'h18);
        chk("region", {6'h0, arr_prot.top_bottom_select, arr_prot.region_size_select},
            8'h03);
        chk("hw protect", {7'h0, hardware_protected_mode}, 8'h01);
        // Program the OTP lock with the pin released, then try to clear it volatilely
        @(negedge clk);
        host.wp_n = 1'b1;
        repeat (4) @(negedge clk);
        cmd(FSP_OP_WRITE_ENABLE_CMD, 8'h00, 8);
        cmd(FSP_OP_WRITE_STATUS_CMD, 8'h80, 16);
        poll_idle();
        read_status_cmd(8'h98);
        chk("otp locked", {7'h0, arr_prot.otp_locked}, 8'h01);
        cmd(FSP_OP_VWREN, 8'h00, 8);
        cmd(FSP_OP_WRITE_STATUS_CMD, 8'h18, 16);
        read_status_cmd(8'h98);
        @(negedge clk);
        host.wp_n = 1'b0;
        repeat (4) @(negedge clk);
        cmd(FSP_OP_WRITE_DISABLE_CMD, 8'h00, 8);
        chk("otp left", {7'h0, otp_mode}, 8'h00);
        cmd(FSP_OP_VWREN, 8'h00, 8);
        cmd(FSP_OP_WRITE_STATUS_CMD, 8'h00, 16);
        read_status_cmd(8'h8C);
        @(negedge clk);
        host.wp_n = 1'b1;
        host.hold_n = 1'b0;
        repeat (4) @(negedge clk);
        chk("hold pin", {6'h0, hold_active, hw_reset_req}, 8'h02);
        host.hold_n = 1'b1;
        repeat (4) @(negedge clk);
        cmd(FSP_OP_QUAD_ON, 8'h00, 8);
        chk("quad on", {7'h0, quad_command_mode}, 8'h01);
        host.quad = 1'b1;
        host.wp_n = 1'b0;
        repeat (4) @(negedge clk);
        chk("quad mute", {7'h0, hardware_protected_mode}, 8'h00);
        read_status_cmd(8'h8C);
        cmd(FSP_OP_QUAD_OFF, 8'h00, 8);
        host.quad = 1'b0;
        chk("quad off", {7'h0, quad_command_mode}, 8'h00);
        results();
    end
endmodule

// [verif/fsp_host_model.sv]
// Host link model: frames commands, clocking the link only inside frames
module fsp_host_model (
    output logic sclk,
    output logic cs_n,
    output logic [3:0] dq_i,
    input wire logic [3:0] dq_o,
    input wire logic [3:0] dq_oe
);
    timeunit 1ns;
    timeprecision 1ns;
    logic wp_n = 1'b1;
    logic hold_n = 1'b1;
    logic quad = 1'b0;
    logic [3:0] drv = 4'h0;
    logic [3:0] oe_last = 4'h0;
    initial begin
        sclk = 1'b0;
        #1 cs_n = 1'b1; // A clean rising edge clears the device's frame logic
    end
    // Pin functions share the upper lines, quad frames take them as data
    assign dq_i = (quad && !cs_n) ? drv : {hold_n, wp_n, drv[1:0]};
    // One frame of nb bit times, MSB first; rd keeps the last byte seen
    task automatic xfer(input logic [7:0] op, input logic [7:0] dat, input int nb,
        output logic [7:0] rd);
        logic [15:0] sh;
        int st;
        sh = {op, dat};
        st = quad ? 4 : 1;
        rd = 8'h00;
        cs_n = 1'b0;
        for (int i = 0; i < nb; i += st) begin
            if (i < 16) begin
                drv = quad ? sh[15-i -: 4] : {2'h0, ~drv[1], sh[15-i]};
            end else begin
                drv = ~drv; // Released lines never keep their last level
            end
            #15 sclk = 1'b1;
            rd = quad ? {rd[3:0], dq_o} : {rd[6:0], dq_o[1]};
            oe_last = dq_oe;
            #15 sclk = 1'b0;
        end
        #15 cs_n = 1'b1;
        #700; // Gap covers the clk-domain execute delay
    endtask
endmodule
